// ---- laser_supervisor_pkg.sv ----
package laser_supervisor_pkg;
    // ---------------------------------------------------------------
    // timebase
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS      = 8000;
    // ---------------------------------------------------------------
    // printed times
    // ---------------------------------------------------------------
    localparam int T_OFF_US           = 10;
    localparam int T_ON_MS            = 1;
    localparam int T_INIT_MS          = 300;
    localparam int T_FAULT_US         = 100;
    localparam int T_RESET_US         = 10;
    localparam int T_LOSS_US          = 100;
    localparam int F_SERIAL_KHZ       = 400;
    // ---------------------------------------------------------------
    // derived counts (longest times round down, least time rounds up)
    // ---------------------------------------------------------------
    localparam int T_OFF_CYC          = (T_OFF_US * 1000000) / CLK_PERIOD_PS;
    localparam int T_ON_CYC           = (T_ON_MS * 1000000000) / CLK_PERIOD_PS;
    localparam int T_INIT_CYC         = T_INIT_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int T_FAULT_CYC        = (T_FAULT_US * 1000000) / CLK_PERIOD_PS;
    localparam int T_RESET_CYC        = (T_RESET_US * 1000000 + CLK_PERIOD_PS - 1)
                                        / CLK_PERIOD_PS;
    localparam int T_LOSS_CYC         = (T_LOSS_US * 1000000) / CLK_PERIOD_PS;
    localparam int SCL_MIN_PERIOD_CYC = (1000000000 / F_SERIAL_KHZ + CLK_PERIOD_PS - 1)
                                        / CLK_PERIOD_PS;
    // ---------------------------------------------------------------
    // widths and filter length used inside the block; the response delays are not used
    // ---------------------------------------------------------------
    localparam int CNT_W              = 26;
    localparam int LOSS_FILT_CYC      = 16;
    localparam int OFF_DELAY_CYC      = 2;
    localparam int FAULT_DELAY_CYC    = 4;

    typedef enum logic [2:0] {
        st_init,
        st_running,
        st_disabled,
        st_faulted,
        st_clearing
    } sup_state_t;
endpackage : laser_supervisor_pkg

// ---- serial_clock_limiter.sv ----
`timescale 1ns/100ps
module serial_clock_limiter #(
    parameter int MIN_PERIOD = laser_supervisor_pkg::SCL_MIN_PERIOD_CYC
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic scl_in,
    output logic      scl_too_fast
);
    import laser_supervisor_pkg::*;

    logic [15:0] period;
    logic [15:0] next_period;
    logic        scl_prev;
    logic        next_too_fast;

    // ---------------------------------------------------------------
    // rising-edge spacing check
    // ---------------------------------------------------------------
    always_comb begin
        next_too_fast = scl_too_fast;
        next_period   = (period == 16'hFFFF) ? period : period + 16'h0001;
        if (scl_in && !scl_prev) begin
            next_too_fast = (period < MIN_PERIOD[15:0]);
            next_period   = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            period       <= 16'hFFFF;
            scl_prev     <= 1'b1;
            scl_too_fast <= 1'b0;
        end else begin
            period       <= next_period;
            scl_prev     <= scl_in;
            scl_too_fast <= next_too_fast;
        end
    end
endmodule : serial_clock_limiter

// ---- laser_fault_los_supervisor.sv ----
// Functional notes
// - laser off within 10 us of disable
// - laser on within 1 ms after enable
// - initialize in 300 ms, clear fault
// - fault output within 100 us of fault
// - signal lost flag set within 100 us
// - signal lost flag cleared within 100 us
// - disable high or open turns laser off; only a driven high does here, an open input is not pulled high
// - fault and signal lost active high
`timescale 1ns/100ps
module laser_fault_los_supervisor #(
    parameter int INIT_CYCLES  = laser_supervisor_pkg::T_INIT_CYC,
    parameter int ON_CYCLES    = laser_supervisor_pkg::T_ON_CYC,
    parameter int RESET_CYCLES = laser_supervisor_pkg::T_RESET_CYC,
    parameter int LOSS_CYCLES  = laser_supervisor_pkg::LOSS_FILT_CYC
) (
    input  wire logic                            clk,
    input  wire logic                            resetn,
    input  wire logic                            tx_disable,
    input  wire logic                            laser_fault_det,
    input  wire logic                            rx_power_low,
    input  wire logic                            scl_in,
    output logic                                 laser_enable,
    output logic                                 tx_fault,
    output logic                                 rx_signal_lost,
    output logic                                 scl_too_fast,
    output laser_supervisor_pkg::sup_state_t     sup_state
);
    import laser_supervisor_pkg::*;

    sup_state_t        next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic              next_laser_enable;
    logic              next_tx_fault;
    logic [7:0]        loss_cnt;
    logic [7:0]        next_loss_cnt;
    logic              next_signal_lost;
    logic              disable_prev;
    logic              next_disable_prev;
    logic              fault_seen;
    logic              next_fault_seen;
    logic              disable_rise;
    logic              init_done;
    logic              clear_done;

    // ---------------------------------------------------------------
    // input history and counter decodes
    // ---------------------------------------------------------------
    always_comb begin
        next_disable_prev = tx_disable;
        next_fault_seen   = laser_fault_det;
        // only a fresh rise of disable may start a clear
        disable_rise      = tx_disable && !disable_prev;
        init_done         = (cnt >= INIT_CYCLES[CNT_W-1:0] - 1'b1);
        clear_done        = (cnt >= RESET_CYCLES[CNT_W-1:0] - 1'b1);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            disable_prev <= 1'b1;
            fault_seen   <= 1'b0;
        end else begin
            disable_prev <= next_disable_prev;
            fault_seen   <= next_fault_seen;
        end
    end

    // ---------------------------------------------------------------
    // supervisor state and laser drive
    // ---------------------------------------------------------------
    always_comb begin
        next_state        = sup_state;
        next_laser_enable = 1'b0;
        case (sup_state)
            st_init: begin
                // a fault seen during init wins over its end
                if (fault_seen) begin
                    next_state = st_faulted;
                end else if (init_done) begin
                    next_state = tx_disable ? st_disabled : st_running;
                end
            end
            st_running: begin
                next_laser_enable = 1'b1;
                if (fault_seen) begin
                    next_laser_enable = 1'b0;
                    next_state        = st_faulted;
                end else if (tx_disable) begin
                    next_laser_enable = 1'b0;
                    next_state        = st_disabled;
                end
            end
            st_disabled: begin
                if (fault_seen) begin
                    next_state = st_faulted;
                end else if (!tx_disable) begin
                    next_laser_enable = 1'b1;
                    next_state        = st_running;
                end
            end
            st_faulted: begin
                // laser stays off here whatever disable does
                if (disable_rise) begin
                    next_state = st_clearing;
                end
            end
            st_clearing: begin
                if (!tx_disable) begin
                    // a short pulse leaves the fault latched
                    next_state = clear_done ? st_init : st_faulted;
                end
            end
            default: begin
                next_state = st_init;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sup_state    <= st_init;
            laser_enable <= 1'b0;
        end else begin
            sup_state    <= next_state;
            laser_enable <= next_laser_enable;
        end
    end

    // ---------------------------------------------------------------
    // phase counter: init length and clear hold time
    // ---------------------------------------------------------------
    always_comb begin
        next_cnt = '0;
        case (sup_state)
            st_init: begin
                if (!fault_seen && !init_done) begin
                    next_cnt = cnt + 1'b1;
                end
            end
            st_clearing: begin
                // saturate so a very long hold cannot wrap
                if (tx_disable) begin
                    next_cnt = (cnt == {CNT_W{1'b1}}) ? cnt : cnt + 1'b1;
                end
            end
            default: begin
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // ---------------------------------------------------------------
    // fault latch: set by any seen fault, cleared only by init
    // ---------------------------------------------------------------
    always_comb begin
        next_tx_fault = tx_fault;
        case (sup_state)
            st_init: begin
                if (fault_seen) begin
                    next_tx_fault = 1'b1;
                end else if (init_done) begin
                    next_tx_fault = 1'b0;
                end
            end
            st_running, st_disabled: begin
                if (fault_seen) begin
                    next_tx_fault = 1'b1;
                end
            end
            st_faulted, st_clearing: begin
                next_tx_fault = 1'b1;
            end
            default: begin
                next_tx_fault = tx_fault;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_fault <= 1'b1;
        end else begin
            tx_fault <= next_tx_fault;
        end
    end

    // ---------------------------------------------------------------
    // receive signal loss filter
    // ---------------------------------------------------------------
    always_comb begin
        next_signal_lost = rx_signal_lost;
        next_loss_cnt    = '0;
        if (rx_power_low != rx_signal_lost) begin
            next_loss_cnt = loss_cnt + 8'h01;
            if (loss_cnt >= LOSS_CYCLES[7:0] - 8'h01) begin
                next_signal_lost = rx_power_low;
                next_loss_cnt    = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_signal_lost <= 1'b1;
            loss_cnt       <= '0;
        end else begin
            rx_signal_lost <= next_signal_lost;
            loss_cnt       <= next_loss_cnt;
        end
    end

    // ---------------------------------------------------------------
    // identification clock rate monitor
    // ---------------------------------------------------------------
    serial_clock_limiter u_scl (
        .clk          (clk),
        .resetn       (resetn),
        .scl_in       (scl_in),
        .scl_too_fast (scl_too_fast)
    );
endmodule : laser_fault_los_supervisor

// ---- laser_fault_los_supervisor_assertions.sv ----
`timescale 1ns/100ps
module laser_supervisor_chk
    import laser_supervisor_pkg::*;
#(
    parameter int INIT_CYCLES = 50,
    parameter int LOSS_CYCLES = 16
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       tx_disable,
    input wire logic       laser_fault_det,
    input wire logic       rx_power_low,
    input wire logic       laser_enable,
    input wire logic       tx_fault,
    input wire logic       rx_signal_lost,
    input wire sup_state_t sup_state
);
    int init_cnt;
    int loss_run;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            init_cnt <= 0;
            loss_run <= 0;
        end else begin
            init_cnt <= (sup_state == st_init) ? init_cnt + 1 : 0;
            loss_run <= (rx_power_low != rx_signal_lost) ? loss_run + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_laser_off: assert property (sup_state == st_running && tx_disable
        |=> !laser_enable)
        else $error("laser stayed on after disable");
    chk_laser_on: assert property (sup_state == st_disabled && !tx_disable
        && !$past(laser_fault_det) |=> laser_enable)
        else $error("laser not enabled");
    chk_init_len: assert property (init_cnt <= INIT_CYCLES + 1)
        else $error("init too long");
    chk_init_end: assert property ($fell(tx_fault) |-> init_cnt >= INIT_CYCLES - 1)
        else $error("fault cleared early");
    chk_fault_rise: assert property (laser_fault_det |-> ##2 tx_fault)
        else $error("fault output late");
    chk_disable_off: assert property ($past(tx_disable) |-> !laser_enable)
        else $error("laser on while disabled");
    chk_fault_held: assert property (sup_state == st_faulted
        |=> tx_fault && !laser_enable)
        else $error("fault not latched");
    chk_loss_time: assert property (loss_run <= LOSS_CYCLES + 1)
        else $error("loss output late");
    chk_loss_pol: assert property ($changed(rx_signal_lost)
        |-> rx_signal_lost == $past(rx_power_low))
        else $error("loss output polarity");
    cover property (sup_state == st_faulted);
    cover property ($fell(tx_fault));
    cover property ($rose(rx_signal_lost));
endmodule : laser_supervisor_chk
bind laser_fault_los_supervisor laser_supervisor_chk #(.INIT_CYCLES(INIT_CYCLES),
    .LOSS_CYCLES(LOSS_CYCLES)) u_laser_supervisor_chk (.clk(clk), .resetn(resetn),
    .tx_disable(tx_disable), .laser_fault_det(laser_fault_det), .rx_power_low(rx_power_low),
    .laser_enable(laser_enable), .tx_fault(tx_fault), .rx_signal_lost(rx_signal_lost),
    .sup_state(sup_state));

// ---- host_port_model.sv ----
`timescale 1ns/100ps
module host_port_model (
    input  wire logic   clk,
    input  wire logic   resetn,
    input  wire logic   clear_go,
    input  wire logic   dis_lvl,
    input  wire logic   scl_en,
    input  wire integer hold,
    input  wire integer half,
    output logic        tx_disable,
    output logic        scl_in
);
    int pulse;
    int sc;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse  <= 0;
            sc     <= 0;
            scl_in <= 1'b1;
        end else begin
            pulse <= clear_go ? hold : (pulse > 0 ? pulse - 1 : 0);
            sc    <= (sc >= half - 1) ? 0 : sc + 1;
            if (!scl_en)
                scl_in <= 1'b1;
            else if (sc >= half - 1)
                scl_in <= ~scl_in;
        end
    end
    assign tx_disable = dis_lvl | (pulse > 0);
endmodule : host_port_model

// ---- laser_fault_los_supervisor_tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %0b seen %0b", n, e, g); end end
module laser_fault_los_supervisor_tb;
    import laser_supervisor_pkg::*;
    localparam int INIT = 50;
    localparam int LOSS = 16;
    logic       clk, resetn, fault_det, power_low, clear_go, dis_lvl, scl_en;
    logic       tx_disable, scl_in, laser_enable, tx_fault, rx_signal_lost, scl_too_fast;
    sup_state_t sup_state;
    int         hold, half, bad_count, tests_run, cycles, lfsr, i;
    int         model_run;
    logic       model_lost;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    host_port_model u_host_port_model (.clk(clk), .resetn(resetn), .clear_go(clear_go),
        .dis_lvl(dis_lvl), .scl_en(scl_en), .hold(hold), .half(half),
        .tx_disable(tx_disable), .scl_in(scl_in));
    laser_fault_los_supervisor #(.INIT_CYCLES(INIT), .RESET_CYCLES(8), .LOSS_CYCLES(LOSS))
        u_laser_fault_los_supervisor (.clk(clk), .resetn(resetn), .tx_disable(tx_disable),
        .laser_fault_det(fault_det), .rx_power_low(power_low), .scl_in(scl_in),
        .laser_enable(laser_enable), .tx_fault(tx_fault), .rx_signal_lost(rx_signal_lost),
        .scl_too_fast(scl_too_fast), .sup_state(sup_state));
    function automatic int next_rand(int x);
        return {15'h0, x[15:0], x[16] ^ x[13]};
    endfunction : next_rand
    task automatic wait_cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic check(logic on, logic flt);
        `CHK("laser_enable", on, laser_enable)
        `CHK("tx_fault", flt, tx_fault)
    endtask : check
    task automatic clear_pulse(int n);
        @(posedge clk) hold <= n;
        clear_go <= 1'b1;
        @(posedge clk) clear_go <= 1'b0;
    endtask : clear_pulse
    task automatic stop_test();
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            model_run  <= 0;
            model_lost <= 1'b1;
        end else if (power_low == model_lost) begin
            model_run <= 0;
        end else if (model_run == LOSS - 1) begin
            model_run  <= 0;
            model_lost <= power_low;
        end else begin
            model_run <= model_run + 1;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        {resetn, fault_det, power_low, clear_go, dis_lvl, scl_en} = 6'h00;
        {hold, half, bad_count, tests_run, cycles, lfsr} = {32'd10, 32'd50, 96'h0, 32'd82446};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        wait_cyc(INIT + 20);
        check(1'b1, 1'b0);
        `CHK("rx_signal_lost", 1'b0, rx_signal_lost)
        @(posedge clk) dis_lvl <= 1'b1;
        wait_cyc(3);
        check(1'b0, 1'b0);
        @(posedge clk) dis_lvl <= 1'b0;
        wait_cyc(3);
        check(1'b1, 1'b0);
        for (i = 0; i < 8; i++) begin
            lfsr = next_rand(lfsr);
            @(posedge clk) power_low <= lfsr[0];
            wait_cyc(LOSS + 3);
            `CHK("rx_signal_lost", lfsr[0], rx_signal_lost)
            `CHK("rx_signal_lost model", model_lost, rx_signal_lost)
        end
        @(posedge clk) fault_det <= 1'b1;
        @(posedge clk) fault_det <= 1'b0;
        wait_cyc(2);
        check(1'b0, 1'b1);
        `CHK("sup_state", st_faulted, sup_state)
        wait_cyc(20);
        check(1'b0, 1'b1);
        clear_pulse(3);
        wait_cyc(10);
        check(1'b0, 1'b1);
        clear_pulse(10);
        wait_cyc(20);
        @(posedge clk) dis_lvl <= 1'b1;
        wait_cyc(INIT);
        check(1'b0, 1'b0);
        `CHK("sup_state", st_disabled, sup_state)
        @(posedge clk) dis_lvl <= 1'b0;
        wait_cyc(3);
        check(1'b1, 1'b0);
        @(posedge clk) scl_en <= 1'b1;
        wait_cyc(1500);
        `CHK("scl_too_fast", 1'b1, scl_too_fast)
        @(posedge clk) half <= 200;
        wait_cyc(1500);
        `CHK("scl_too_fast", 1'b0, scl_too_fast)
        stop_test();
    end
endmodule : laser_fault_los_supervisor_tb
